// File: dv/fast_detect_and_monitor_sync_test.sv
// Testbench: register port, thresholds and dwell, sync modes, interrupt
// Assumes the source model delays samples and edges by one cycle
`timescale 1ns/1ps
module fast_detect_and_monitor_sync_test
  import fd_pkg::*;
;
  localparam int         PER = 8;
  localparam logic [9:0] OFFS [7] = '{OFF_UP_LOW, OFF_UP_HIGH, OFF_LO_LOW, OFF_LO_HIGH,
                                      OFF_DW_LOW, OFF_DW_HIGH, OFF_SYNC_CTRL};
  logic        sys_clk_in = 1'b0, rst_in = 1'b1, wr = 1'b0, rd = 1'b0;
  logic        vld_m = 1'b0, ref_on = 1'b0, vld, sref, flag, sync, irq;
  logic [9:0]  addr = 10'h000;
  logic [7:0]  wdata = 8'h00, rdata;
  logic [12:0] mag_m = 13'h0000, mag;
  int          fails = 0, n_tests = 0, ne, np;
  always #4 sys_clk_in = ~sys_clk_in;
  fd_source_model #(.PER(PER)) src_u (.sys_clk_in, .ref_on_in(ref_on), .vld_in(vld_m),
    .mag_in(mag_m), .vld_out(vld), .edge_out(sref), .mag_out(mag));
  fast_detect_and_monitor_sync dut_u (.sys_clk_in, .rst_in, .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .sample_mag_in(mag), .sample_valid_in(vld), .sysref_edge_in(sref),
    .overrange_flag_pin_any_out(flag), .monitor_sync_out(sync), .irq_out(irq));
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %0h vs %0h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(logic [9:0] a, logic [7:0] d);
    @(posedge sys_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(logic [9:0] a, logic [7:0] e);
    @(posedge sys_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_in);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic samp(logic [12:0] m, logic e);
    @(posedge sys_clk_in);
    mag_m <= m;
    vld_m <= 1'b1;
    @(posedge sys_clk_in);
    vld_m <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    #1 chk(flag, e);
  endtask
  task automatic run_ref(int n);
    ne = 0;
    np = 0;
    for (int i = 0; i < n + 4; i++) begin
      @(posedge sys_clk_in);
      ref_on <= i < n;
      #1 ne += int'(sref);
      np += int'(sync);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    foreach (OFFS[i]) rd_chk(OFFS[i], 8'h00);
    wr_reg(10'h300, 8'hFF);
    rd_chk(10'h300, 8'h00);
    wr_reg(OFF_UP_LOW, 8'h34);
    wr_reg(OFF_UP_HIGH, 8'hE1);
    wr_reg(OFF_LO_LOW, 8'h10);
    wr_reg(OFF_LO_HIGH, 8'hE0);
    wr_reg(OFF_DW_LOW, 8'h02);
    wr_reg(OFF_DW_HIGH, 8'hA5);
    rd_chk(OFF_UP_HIGH, 8'h01);
    rd_chk(OFF_LO_HIGH, 8'h00);
    rd_chk(OFF_DW_HIGH, 8'hA5);
    wr_reg(OFF_DW_HIGH, 8'h00);
    $display("registers done");
    wr_reg(OFF_IRQ_MASK, 8'h07);
    rd_chk(OFF_IRQ_MASK, 8'h07);
    wr_reg(OFF_FD_CTRL, 8'h01);
    samp(13'h134, 1'b0);
    samp(13'h135, 1'b1);
    chk(irq, 1'b1);
    rd_chk(OFF_IRQ_STATUS, 8'h01);
    chk(irq, 1'b0);
    samp(13'h005, 1'b1);
    samp(13'h005, 1'b1);
    samp(13'h010, 1'b1);
    samp(13'h00F, 1'b1);
    samp(13'h00F, 1'b1);
    samp(13'h00F, 1'b0);
    rd_chk(OFF_IRQ_STATUS, 8'h02);
    $display("detect done");
    wr_reg(OFF_SYNC_CTRL, 8'h01);
    run_ref(4 * PER);
    chk(16'(np), 16'(ne));
    chk(ne > 2, 1'b1);
    rd_chk(OFF_IRQ_STATUS, 8'h04);
    wr_reg(OFF_SYNC_CTRL, 8'h00);
    run_ref(2 * PER);
    chk(16'(np), 16'h0000);
    wr_reg(OFF_SYNC_CTRL, 8'h03);
    run_ref(4 * PER);
    chk(16'(np), 16'h0001);
    rd_chk(OFF_SYNC_CTRL, 8'h02);
    chk(irq, 1'b1);
    wr_reg(OFF_IRQ_MASK, 8'h00);
    #1 chk(irq, 1'b0);
    rd_chk(OFF_IRQ_STATUS, 8'h04);
    $display("sync done");
    wr_reg(OFF_FD_CTRL, 8'hFF);
    #1 chk(flag, 1'b1);
    rd_chk(OFF_FD_CTRL, 8'h0D);
    wr_reg(OFF_FD_CTRL, 8'h0C);
    #1 chk(flag, 1'b0);
    wr_reg(OFF_FD_CTRL, 8'h01);
    samp(13'h135, 1'b1);
    wr_reg(OFF_FD_CTRL, 8'h09);
    #1 chk(flag, 1'b0);
    wr_reg(OFF_FD_CTRL, 8'h01);
    #1 chk(flag, 1'b1);
    wr_reg(OFF_FD_CTRL, 8'h00);
    samp(13'h1FF, 1'b0);
    $display("force done");
    report_and_stop;
  end
  initial begin
    #700us;
    fails++;
    report_and_stop;
  end
endmodule

// File: dv/fd_monitor_sva.sv
// Checker: fast detect pin and monitor sync timing at the block ports
// Assumes registers change only through the byte port
`timescale 1ns/1ps
module fd_monitor_sva
  import fd_pkg::*;
#(parameter int MAG_W = THR_W) (
  input wire logic             sys_clk_in,
  input wire logic             rst_in,
  input wire logic [9:0]       reg_addr_in,
  input wire logic [7:0]       reg_wdata_in,
  input wire logic             reg_wr_in,
  input wire logic [MAG_W-1:0] sample_mag_in,
  input wire logic             sample_valid_in,
  input wire logic             sysref_edge_in,
  input wire logic             overrange_flag_pin_any_out,
  input wire logic             monitor_sync_out
);
  logic [7:0]  sh_q [10'h245:10'h26F];
  logic [16:0] run_q;
  logic        en_q;
  wire  [12:0] up   = {sh_q[OFF_UP_HIGH][4:0], sh_q[OFF_UP_LOW]};
  wire  [12:0] lo   = {sh_q[OFF_LO_HIGH][4:0], sh_q[OFF_LO_LOW]};
  wire  [15:0] dw   = {sh_q[OFF_DW_HIGH], sh_q[OFF_DW_LOW]};
  wire  [7:0]  ctl  = sh_q[OFF_FD_CTRL];
  wire  [7:0]  syc  = sh_q[OFF_SYNC_CTRL];
  wire         syen = syc[BIT_SYNC_EN];
  wire         norm = ctl[BIT_FD_EN] && !ctl[BIT_FORCE];
  wire         big  = sample_valid_in && sample_mag_in > up;
  wire         low  = sample_valid_in && sample_mag_in < lo;
  wire         flag = overrange_flag_pin_any_out;
  wire         hit  = reg_wr_in && reg_addr_in inside {[OFF_FD_CTRL:OFF_SYNC_CTRL]};
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sh_q <= '{default: 8'h00};
      run_q <= '0;
      en_q <= 1'b0;
    end else begin
      en_q <= syen;
      if (hit)
        sh_q[reg_addr_in] <= reg_wdata_in;
      if (en_q && syen && sysref_edge_in && syc[BIT_SYNC_ONCE])
        sh_q[OFF_SYNC_CTRL][BIT_SYNC_EN] <= 1'b0;
      if (sample_valid_in)
        run_q <= low ? run_q + 17'h00001 : '0;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  sequence armed_edge_s;
    syen ##1 syen && !syc[BIT_SYNC_ONCE] && sysref_edge_in;
  endsequence
  fd_off_a: assert property (!ctl[BIT_FD_EN] |-> !flag)
    else $error("pin high while disabled");
  fd_force_a: assert property (ctl[BIT_FD_EN] && ctl[BIT_FORCE]
    |-> flag == ctl[BIT_FORCE_VAL]) else $error("pin not at forced value");
  fd_set_a: assert property (norm && big |=> flag)
    else $error("pin not set above upper");
  fd_rise_a: assert property (norm && $past(norm) && $rose(flag) |-> $past(big))
    else $error("pin rose without high sample");
  fd_fall_a: assert property (norm && $past(norm) && $fell(flag)
    |-> $past(low) && run_q > dw) else $error("pin released early");
  sync_why_a: assert property (monitor_sync_out |-> $past(sysref_edge_in) && $past(syen))
    else $error("sync without enabled edge");
  sync_each_a: assert property (armed_edge_s |=> monitor_sync_out)
    else $error("continuous edge missed");
  sync_once_a: assert property (monitor_sync_out && syc[BIT_SYNC_ONCE] |=> !monitor_sync_out [*2])
    else $error("one-shot sync repeated");
endmodule
bind fast_detect_and_monitor_sync fd_monitor_sva #(.MAG_W(MAG_W)) chk_u (.sys_clk_in, .rst_in,
  .reg_addr_in, .reg_wdata_in, .reg_wr_in, .sample_mag_in, .sample_valid_in, .sysref_edge_in,
  .overrange_flag_pin_any_out, .monitor_sync_out);

// File: dv/fd_source_model.sv
// Source model: converter samples and periodic reference edges
// Assumes the bench requests samples and reference traffic per cycle
`timescale 1ns/1ps
module fd_source_model #(parameter int PER = 8) (
  input  wire logic        sys_clk_in,
  input  wire logic        ref_on_in,
  input  wire logic        vld_in,
  input  wire logic [12:0] mag_in,
  output logic             vld_out,
  output logic             edge_out,
  output logic      [12:0] mag_out
);
  int cnt = 0;
  initial mag_out = 13'h0000;
  always @(posedge sys_clk_in) begin
    cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    edge_out <= ref_on_in && cnt == 0;
    vld_out <= vld_in;
    mag_out <= vld_in ? mag_in : ~mag_out;
  end
endmodule

// File: hw/fast_detect_and_monitor_sync.sv
// Fast detect threshold/dwell logic and signal monitor sync control
// Assumes samples and sync reference edges synchronous to sys_clk_in
`timescale 1ns/1ps
module fast_detect_and_monitor_sync
  import fd_pkg::*;
#(
  parameter int MAG_W = THR_W
) (
  input  wire logic              sys_clk_in,
  input  wire logic              rst_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [DATA_W-1:0] reg_rdata_out,
  input  wire logic [MAG_W-1:0]  sample_mag_in,
  input  wire logic              sample_valid_in,
  input  wire logic              sysref_edge_in,
  output logic                   overrange_flag_pin_any_out,
  output logic                   monitor_sync_out,
  output logic                   irq_out
);
  reg_req_s    req;
  logic [7:0]  fd_ctrl_q;
  logic [7:0]  up_low_q;
  logic [4:0]  up_high_q;
  logic [7:0]  lo_low_q;
  logic [4:0]  lo_high_q;
  logic [7:0]  dw_low_q;
  logic [7:0]  dw_high_q;
  logic [1:0]  sync_ctrl_q;
  logic [2:0]  irq_stat_q;
  logic [2:0]  irq_stat_d;
  logic [2:0]  irq_mask_q;
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;
  logic        detect_q;
  logic        detect_d;
  logic        sync_pulse_q;
  sync_state_e sync_state_q;
  sync_state_e sync_state_d;

  assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [7:0] pad_byte(input logic [4:0] v);
    pad_byte = {3'h0, v};
  endfunction

  // Register write strobes and the status read strobe
  wire wr_fd_ctrl  = req.wr && hit(req.addr, OFF_FD_CTRL);
  wire wr_up_low   = req.wr && hit(req.addr, OFF_UP_LOW);
  wire wr_up_high  = req.wr && hit(req.addr, OFF_UP_HIGH);
  wire wr_lo_low   = req.wr && hit(req.addr, OFF_LO_LOW);
  wire wr_lo_high  = req.wr && hit(req.addr, OFF_LO_HIGH);
  wire wr_dw_low   = req.wr && hit(req.addr, OFF_DW_LOW);
  wire wr_dw_high  = req.wr && hit(req.addr, OFF_DW_HIGH);
  wire wr_sync     = req.wr && hit(req.addr, OFF_SYNC_CTRL);
  wire wr_mask     = req.wr && hit(req.addr, OFF_IRQ_MASK);
  wire rd_stat     = req.rd && hit(req.addr, OFF_IRQ_STATUS);

  // Thresholds and dwell target assembly
  wire [THR_W-1:0]   upper_thr = {up_high_q, up_low_q};
  wire [THR_W-1:0]   lower_thr = {lo_high_q, lo_low_q};
  wire [DWELL_W-1:0] dwell_tgt = {dw_high_q, dw_low_q};

  wire fd_enable   = fd_ctrl_q[BIT_FD_EN];
  wire above_upper = sample_valid_in && (sample_mag_in > upper_thr);
  wire below_lower = sample_valid_in && (sample_mag_in < lower_thr);
  wire not_below   = sample_valid_in && !below_lower;
  wire dwell_done;

  // Dwell counter runs only while detected
  fd_dwell_timer #(
    .W (DWELL_W)
  ) u_dwell (
    .sys_clk_in  (sys_clk_in),
    .rst_in      (rst_in),
    .step_in     (below_lower && detect_q),
    .restart_in  (not_below || !detect_q),
    .target_in   (dwell_tgt),
    .expired_out (dwell_done)
  );

  // Detection state: set above upper, clear after dwell below lower
  always_comb begin
    detect_d = detect_q;
    if (!fd_enable) begin
      detect_d = 1'b0;
    end else if (above_upper) begin
      detect_d = 1'b1;
    end else if (detect_q && below_lower && dwell_done) begin
      detect_d = 1'b0;
    end
  end

  // Pin drive: force overrides comparison, enable gates both
  wire pin_val = fd_ctrl_q[BIT_FORCE] ? fd_ctrl_q[BIT_FORCE_VAL] : detect_q;
  assign overrange_flag_pin_any_out = fd_enable && pin_val;

  // Monitor sync state machine
  wire sync_en   = sync_ctrl_q[BIT_SYNC_EN];
  wire sync_once = sync_ctrl_q[BIT_SYNC_ONCE];
  wire sync_fire = (sync_state_q == SYNC_ARMED) && sync_en && sysref_edge_in;

  always_comb begin
    sync_state_d = sync_state_q;
    case (sync_state_q)
      SYNC_IDLE: begin
        if (sync_en) begin
          sync_state_d = SYNC_ARMED;
        end
      end
      SYNC_ARMED: begin
        if (!sync_en) begin
          sync_state_d = SYNC_IDLE;
        end else if (sysref_edge_in && sync_once) begin
          sync_state_d = SYNC_DONE;
        end
      end
      SYNC_DONE: begin
        if (!sync_en) begin
          sync_state_d = SYNC_IDLE;
        end
      end
      default: sync_state_d = SYNC_IDLE;
    endcase
  end

  // Interrupt events: detect set, detect release, sync fired
  wire once_capture = sync_fire && sync_once;
  wire edge_set     = ~detect_q & detect_d;
  wire edge_clr     = detect_q & ~detect_d;
  wire [2:0] irq_evt = {sync_fire, edge_clr, edge_set};

  // Sticky status, set wins over read clear
  assign irq_stat_d = (rd_stat ? 3'h0 : irq_stat_q) | irq_evt;
  assign irq_out    = |(irq_stat_q & irq_mask_q);

  // Read mux
  always_comb begin
    rdata_d = 8'h00;
    if (hit(req.addr, OFF_FD_CTRL)) begin
      rdata_d = {4'h0, fd_ctrl_q[3:2], 1'b0, fd_ctrl_q[0]};
    end else if (hit(req.addr, OFF_UP_LOW)) begin
      rdata_d = up_low_q;
    end else if (hit(req.addr, OFF_UP_HIGH)) begin
      rdata_d = pad_byte(up_high_q);
    end else if (hit(req.addr, OFF_LO_LOW)) begin
      rdata_d = lo_low_q;
    end else if (hit(req.addr, OFF_LO_HIGH)) begin
      rdata_d = pad_byte(lo_high_q);
    end else if (hit(req.addr, OFF_DW_LOW)) begin
      rdata_d = dw_low_q;
    end else if (hit(req.addr, OFF_DW_HIGH)) begin
      rdata_d = dw_high_q;
    end else if (hit(req.addr, OFF_SYNC_CTRL)) begin
      rdata_d = {6'h00, sync_ctrl_q};
    end else if (hit(req.addr, OFF_IRQ_STATUS)) begin
      rdata_d = {5'h00, irq_stat_q};
    end else if (hit(req.addr, OFF_IRQ_MASK)) begin
      rdata_d = {5'h00, irq_mask_q};
    end
  end

  // Register bytes, one short block each
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      fd_ctrl_q <= RST_BYTE;
    end else if (wr_fd_ctrl) begin
      fd_ctrl_q <= req.wdata & 8'h0D;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      up_low_q <= RST_BYTE;
    end else if (wr_up_low) begin
      up_low_q <= req.wdata;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      up_high_q <= RST_BYTE[4:0];
    end else if (wr_up_high) begin
      up_high_q <= req.wdata[4:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      lo_low_q <= RST_BYTE;
    end else if (wr_lo_low) begin
      lo_low_q <= req.wdata;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      lo_high_q <= RST_BYTE[4:0];
    end else if (wr_lo_high) begin
      lo_high_q <= req.wdata[4:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      dw_low_q <= RST_DWELL[7:0];
    end else if (wr_dw_low) begin
      dw_low_q <= req.wdata;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      dw_high_q <= RST_DWELL[15:8];
    end else if (wr_dw_high) begin
      dw_high_q <= req.wdata;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      irq_mask_q <= RST_BYTE[2:0];
    end else if (wr_mask) begin
      irq_mask_q <= req.wdata[2:0];
    end
  end

  // Sync control: hardware clear of enable wins over write
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sync_ctrl_q <= RST_BYTE[1:0];
    end else if (once_capture) begin
      sync_ctrl_q <= {wr_sync ? req.wdata[BIT_SYNC_ONCE] : sync_once, 1'b0};
    end else if (wr_sync) begin
      sync_ctrl_q <= req.wdata[1:0];
    end
  end

  // Pipeline state, one short block each
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sync_state_q <= SYNC_IDLE;
    end else begin
      sync_state_q <= sync_state_d;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sync_pulse_q <= 1'b0;
    end else begin
      sync_pulse_q <= sync_fire;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      detect_q <= 1'b0;
    end else begin
      detect_q <= detect_d;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      irq_stat_q <= 3'h0;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  wire [7:0] rdata_next = req.rd ? rdata_d : 8'h00;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_next;
    end
  end

  assign reg_rdata_out    = rdata_q;
  assign monitor_sync_out = sync_pulse_q;
endmodule

// File: hw/fd_dwell_timer.sv
// Dwell counter: counts samples below the lower threshold
// Assumes one sample per clock with sample_valid_in qualifying it
`timescale 1ns/1ps
module fd_dwell_timer
  import fd_pkg::*;
#(
  parameter int W = DWELL_W
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  input  wire logic         step_in,
  input  wire logic         restart_in,
  input  wire logic [W-1:0] target_in,
  output logic              expired_out
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  wire          at_target = (cnt_q >= target_in);

  // Reload on restart, count up while low
  assign cnt_d = restart_in ? '0 : ((step_in && !at_target) ? cnt_q + 1'b1 : cnt_q);
  assign expired_out = at_target && !restart_in;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// File: hw/fd_pkg.sv
// Package: register offsets, field positions, reset values, carrier types
// Assumes byte-wide register port with 10-bit address
package fd_pkg;
  localparam int          ADDR_W          = 10;
  localparam int          DATA_W          = 8;
  localparam int          THR_W           = 13;
  localparam int          DWELL_W         = 16;
  localparam logic [9:0]  OFF_FD_CTRL     = 10'h245;
  localparam logic [9:0]  OFF_UP_LOW      = 10'h247;
  localparam logic [9:0]  OFF_UP_HIGH     = 10'h248;
  localparam logic [9:0]  OFF_LO_LOW      = 10'h249;
  localparam logic [9:0]  OFF_LO_HIGH     = 10'h24A;
  localparam logic [9:0]  OFF_DW_LOW      = 10'h24B;
  localparam logic [9:0]  OFF_DW_HIGH     = 10'h24C;
  localparam logic [9:0]  OFF_SYNC_CTRL   = 10'h26F;
  localparam logic [9:0]  OFF_IRQ_STATUS  = 10'h2F0;
  localparam logic [9:0]  OFF_IRQ_MASK    = 10'h2F1;
  localparam int          BIT_FD_EN       = 0;
  localparam int          BIT_FORCE_VAL   = 2;
  localparam int          BIT_FORCE       = 3;
  localparam int          BIT_SYNC_EN     = 0;
  localparam int          BIT_SYNC_ONCE   = 1;
  localparam int          IRQ_RISE        = 0;
  localparam int          IRQ_FALL        = 1;
  localparam int          IRQ_SYNC        = 2;
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [15:0] RST_DWELL       = 16'h0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_s;

  typedef enum logic [1:0] {SYNC_IDLE, SYNC_ARMED, SYNC_DONE} sync_state_e;
endpackage
